//--- verilog/icd_pkg.sv
// Package: constants and carrier types for the interrupt class dispatch unit
package icd_pkg;
  localparam int unsigned XLEN = 32;

  // Legacy fixed offsets
  localparam logic [31:0] LEG_OFS_SYSRESET = 32'h0000_0100;
  localparam logic [31:0] LEG_OFS_MCHK     = 32'h0000_0200;
  localparam logic [31:0] LEG_OFS_DSI      = 32'h0000_0300;
  localparam logic [31:0] LEG_OFS_EXT      = 32'h0000_0500;
  localparam logic [11:0] LEG_BASE_LOW     = 12'h000;
  localparam logic [11:0] LEG_BASE_HIGH    = 12'hfff;

  // Offset slot indices
  localparam logic [3:0] SLOT_CRIT = 4'h0;
  localparam logic [3:0] SLOT_MCHK = 4'h1;
  localparam logic [3:0] SLOT_DSI  = 4'h2;
  localparam logic [3:0] SLOT_EXT  = 4'h4;
  localparam logic [3:0] SLOT_EXTU = 4'h5;
  localparam int unsigned NSLOT    = 16;

  // Machine state bit positions
  localparam int unsigned MS_EE = 15;
  localparam int unsigned MS_CE = 17;
  localparam int unsigned MS_ME = 12;
  localparam int unsigned MS_IP = 6;

  // Register port offsets (word index)
  localparam logic [5:0] A_PREFIX    = 6'h00;
  localparam logic [5:0] A_MSTATE    = 6'h01;
  localparam logic [5:0] A_SAVE_PC   = 6'h02;
  localparam logic [5:0] A_SAVE_ST   = 6'h03;
  localparam logic [5:0] A_CSAVE_PC  = 6'h04;
  localparam logic [5:0] A_CSAVE_ST  = 6'h05;
  localparam logic [5:0] A_MSAVE_PC  = 6'h06;
  localparam logic [5:0] A_MSAVE_ST  = 6'h07;
  localparam logic [5:0] A_MSYND     = 6'h08;
  localparam logic [5:0] A_MADDR     = 6'h09;
  localparam logic [5:0] A_ESYND     = 6'h0a;
  localparam logic [5:0] A_DFADDR    = 6'h0b;
  localparam logic [5:0] A_LDSTAT    = 6'h0c;
  localparam logic [5:0] A_LDADDR    = 6'h0d;
  localparam logic [5:0] A_IRQ_STAT  = 6'h0e;
  localparam logic [5:0] A_IRQ_MASK  = 6'h0f;
  localparam logic [5:0] A_STATUS    = 6'h10;
  localparam logic [5:0] A_SLOT_BASE = 6'h20;

  localparam logic [31:0] MSTATE_RST = 32'h0000_0000;
  localparam logic [31:0] PREFIX_RST = 32'h0000_0000;

  // Sticky event bits
  localparam int unsigned EV_MCHK  = 0;
  localparam int unsigned EV_CRIT  = 1;
  localparam int unsigned EV_NONC  = 2;
  localparam int unsigned EV_STOP  = 3;
  localparam int unsigned NEV      = 4;

  typedef enum logic [1:0] {
    ICD_NONCRIT = 2'b00,
    ICD_CRIT    = 2'b01,
    ICD_MCHK    = 2'b10
  } icd_class_e;

  typedef enum logic [1:0] {
    ICD_RUN   = 2'b00,
    ICD_STOP  = 2'b01
  } icd_state_e;

  // Machine-check request: cause and related address
  typedef struct packed {
    logic        valid;
    logic [31:0] cause;
    logic        addr_valid;
    logic [31:0] addr;
  } icd_mchk_s;

  // Data storage fault report
  typedef struct packed {
    logic        valid;
    logic [31:0] cause;
    logic [31:0] ea;
  } icd_dfault_s;

  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [31:0] wdata;
  } icd_reg_s;
endpackage

//--- verilog/icd_vector.sv
// Handler address formation for both vectoring modes
`timescale 1ns/1ps
module icd_vector (
  input  wire logic        legacy_mode,
  input  wire logic        high_base,
  input  wire logic [31:0] prefix,
  input  wire logic [31:0] slot_ofs,
  input  wire logic [31:0] legacy_ofs,
  output logic      [31:0] vec_addr
);
  // Legacy base is 0x000n_nnnn or 0xFFFn_nnnn; prefix mode keeps upper prefix bits
  wire logic [11:0] leg_top = high_base ? icd_pkg::LEG_BASE_HIGH
                                        : icd_pkg::LEG_BASE_LOW;
  wire logic [31:0] leg_addr = {leg_top, legacy_ofs[19:0]};
  wire logic [31:0] pfx_addr = {prefix[31:16], slot_ofs[15:4], 4'h0};
  assign vec_addr = legacy_mode ? leg_addr : pfx_addr;
endmodule

//--- verilog/icd_dispatch.sv
// Interrupt class dispatch: class selection, save/restore pairs, vectoring, syndromes
//
// Behaviour
// - Each return kind restores pc and state from its own class pair.
// - Critical entries save into the critical pair, never the non-critical pair.
// - Critical input, watchdog and debug requests are dispatched as critical.
// - Machine check uses a third pair and its own return.
// - Extension unit requests are dispatched in the non-critical class.
// - Legacy reset vector is 0x100; prefix mode has no reset slot.
// - Critical input is taken through slot zero, or 0x500 legacy, only while critical enable set.
// - Machine check vectors to 0x200 legacy or slot one prefix mode.
// - Machine check with enable clear enters checkstop instead.
// - Machine check writes syndrome and optionally the related address.
// - Machine-check sources include bus parity and invalid physical address.
// - Data fault vectors 0x300 or slot two; prefix records syndrome and address.
// - Legacy data fault records legacy status, and legacy address only for a non-zero status (zero otherwise).
// - Prefix mode handler is prefix combined with the type's slot offset.
// - Legacy base is 0x000 or 0xfff prefix by the high-base bit.
// - External request taken only while pending and external enable is one.
// - Entry saves return pc and state into the class pair before branch.
`timescale 1ns/1ps
module icd_dispatch (
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic                  legacy_mode,
  input  wire logic                  sys_reset_req,
  input  wire logic                  crit_in,
  input  wire logic                  wdog_req,
  input  wire logic                  debug_req,
  input  wire logic                  ext_in,
  input  wire logic                  signal_proc_ext_req,
  input  wire logic                  perf_mon_req,
  input  wire logic                  bus_parity_err,
  input  wire logic                  bad_phys_addr,
  input  wire icd_pkg::icd_mchk_s    mchk_req,
  input  wire icd_pkg::icd_dfault_s  dfault,
  input  wire logic [31:0]           cur_pc,
  input  wire logic                  ret_noncrit,
  input  wire logic                  ret_crit,
  input  wire logic                  ret_mchk,
  input  wire icd_pkg::icd_reg_s     reg_req,
  output logic      [31:0]           reg_rdata,
  output logic                       take_valid,
  output icd_pkg::icd_class_e        take_class,
  output logic      [31:0]           new_pc,
  output logic                       pc_load,
  output logic                       checkstop,
  output logic                       irq
);
  // Pins from other logic on the same clock pass no synchroniser; the machine-check
  // and interrupt-controller lines come from pins and are synchronised.
  logic [1:0] crit_sync;
  logic [1:0] ext_sync;
  logic [1:0] pin_meta, pin_sync; // {bad address, parity}, kept apart for the syndrome
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      crit_sync <= 2'b00;
      ext_sync  <= 2'b00;
      {pin_meta, pin_sync} <= 4'h0;
    end
    else
    begin
      crit_sync <= {crit_sync[0], crit_in};
      ext_sync  <= {ext_sync[0], ext_in};
      {pin_sync, pin_meta} <= {pin_meta, bad_phys_addr, bus_parity_err};
    end
  end

  // Architectural state
  logic [31:0] machine_state;
  logic [31:0] vector_prefix;
  logic [31:0] save_pc, save_state;
  logic [31:0] critical_save_pc, critical_save_state;
  logic [31:0] mchk_save_pc, mchk_save_state;
  logic [31:0] mchk_syndrome, mchk_address;
  logic [31:0] exception_syndrome, data_fault_address;
  logic [31:0] legacy_data_storage_status, legacy_data_address;
  logic [31:0] vector_offset_slot [icd_pkg::NSLOT];
  logic [icd_pkg::NEV-1:0] irq_stat, irq_mask;
  icd_pkg::icd_state_e     run_state;

  wire logic ee = machine_state[icd_pkg::MS_EE];
  wire logic ce = machine_state[icd_pkg::MS_CE];
  wire logic me = machine_state[icd_pkg::MS_ME];
  wire logic hb = machine_state[icd_pkg::MS_IP];
  wire logic running = (run_state == icd_pkg::ICD_RUN);

  // Request sorting into classes
  wire logic mchk_cond = mchk_req.valid | (|pin_sync);
  wire logic mchk_go   = running & mchk_cond & me;
  wire logic stop_go   = running & mchk_cond & ~me;
  wire logic crit_any  = crit_sync[1] | wdog_req | debug_req;
  wire logic crit_go   = running & ~mchk_cond & crit_any & ce;
  wire logic ext_any   = ext_sync[1] & ee;
  wire logic extu_any  = (signal_proc_ext_req | perf_mon_req) & ee;
  wire logic nc_hold   = mchk_cond | (crit_any & ce);
  wire logic reset_go  = running & ~nc_hold & legacy_mode & sys_reset_req;
  wire logic dsi_go    = running & ~nc_hold & ~reset_go & dfault.valid;
  wire logic ext_go    = running & ~nc_hold & ~reset_go & ~dfault.valid & ext_any;
  wire logic extu_go   = running & ~nc_hold & ~reset_go & ~dfault.valid & ~ext_any
                         & extu_any;
  wire logic nc_go     = reset_go | dsi_go | ext_go | extu_go;
  wire logic any_go    = mchk_go | crit_go | nc_go;

  // Slot and legacy offset for the chosen type
  wire logic [3:0] sel_slot =
    mchk_go ? icd_pkg::SLOT_MCHK :
    crit_go ? icd_pkg::SLOT_CRIT :
    dsi_go  ? icd_pkg::SLOT_DSI  :
    ext_go  ? icd_pkg::SLOT_EXT  : icd_pkg::SLOT_EXTU;
  wire logic [31:0] sel_leg =
    mchk_go  ? icd_pkg::LEG_OFS_MCHK :
    reset_go ? icd_pkg::LEG_OFS_SYSRESET :
    dsi_go   ? icd_pkg::LEG_OFS_DSI  : icd_pkg::LEG_OFS_EXT;
  wire logic [31:0] vec_addr;

  icd_vector u_vector (
    .legacy_mode (legacy_mode),
    .high_base   (hb),
    .prefix      (vector_prefix),
    .slot_ofs    (vector_offset_slot[sel_slot]),
    .legacy_ofs  (sel_leg),
    .vec_addr    (vec_addr)
  );

  // Entry clears the class enables; return restores from the class pair
  wire logic [31:0] ms_nc   = machine_state & ~(32'h1 << icd_pkg::MS_EE);
  wire logic [31:0] ms_crit = ms_nc & ~(32'h1 << icd_pkg::MS_CE);
  wire logic [31:0] ms_mchk = ms_crit & ~(32'h1 << icd_pkg::MS_ME);
  wire logic ret_go = running & ~any_go & (ret_mchk | ret_crit | ret_noncrit);
  wire logic [31:0] ret_pc =
    ret_mchk ? mchk_save_pc : ret_crit ? critical_save_pc : save_pc;
  wire logic [31:0] ret_st =
    ret_mchk ? mchk_save_state : ret_crit ? critical_save_state : save_state;

  // Register port decode
  wire logic [5:0] ra = reg_req.addr;
  wire logic [31:0] wd = reg_req.wdata;
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs, input logic st);
    hit = st & (a == ofs);
  endfunction
  wire logic w_slot = reg_req.wr & (ra[5:4] == icd_pkg::A_SLOT_BASE[5:4]);
  wire logic [icd_pkg::NEV-1:0] ev_set = {stop_go, nc_go, crit_go, mchk_go};

  // Class save pairs, machine state, program counter
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      machine_state       <= icd_pkg::MSTATE_RST;
      vector_prefix       <= icd_pkg::PREFIX_RST;
      save_pc             <= '0;
      save_state          <= '0;
      critical_save_pc    <= '0;
      critical_save_state <= '0;
      mchk_save_pc        <= '0;
      mchk_save_state     <= '0;
      new_pc              <= '0;
      pc_load             <= 1'b0;
      take_valid          <= 1'b0;
      take_class          <= icd_pkg::ICD_NONCRIT;
    end
    else
    begin
      pc_load    <= any_go | ret_go;
      take_valid <= any_go;
      if (mchk_go)
      begin
        mchk_save_pc    <= cur_pc;
        mchk_save_state <= machine_state;
        machine_state   <= ms_mchk;
        take_class      <= icd_pkg::ICD_MCHK;
        new_pc          <= vec_addr;
      end
      else if (crit_go)
      begin
        critical_save_pc    <= cur_pc;
        critical_save_state <= machine_state;
        machine_state       <= ms_crit;
        take_class          <= icd_pkg::ICD_CRIT;
        new_pc              <= vec_addr;
      end
      else if (nc_go)
      begin
        save_pc       <= cur_pc;
        save_state    <= machine_state;
        machine_state <= ms_nc;
        take_class    <= icd_pkg::ICD_NONCRIT;
        new_pc        <= vec_addr;
      end
      else if (ret_go)
      begin
        machine_state <= ret_st;
        new_pc        <= ret_pc;
      end
      else
      begin
        if (hit(ra, icd_pkg::A_MSTATE, reg_req.wr))
          machine_state <= wd;
        if (hit(ra, icd_pkg::A_SAVE_PC, reg_req.wr))
          save_pc <= wd;
        if (hit(ra, icd_pkg::A_SAVE_ST, reg_req.wr))
          save_state <= wd;
        if (hit(ra, icd_pkg::A_CSAVE_PC, reg_req.wr))
          critical_save_pc <= wd;
        if (hit(ra, icd_pkg::A_CSAVE_ST, reg_req.wr))
          critical_save_state <= wd;
        if (hit(ra, icd_pkg::A_MSAVE_PC, reg_req.wr))
          mchk_save_pc <= wd;
        if (hit(ra, icd_pkg::A_MSAVE_ST, reg_req.wr))
          mchk_save_state <= wd;
      end
      if (hit(ra, icd_pkg::A_PREFIX, reg_req.wr))
        vector_prefix <= wd;
    end
  end

  // Syndromes and fault addresses; hardware capture wins over a software write
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mchk_syndrome              <= '0;
      mchk_address               <= '0;
      exception_syndrome         <= '0;
      data_fault_address         <= '0;
      legacy_data_storage_status <= '0;
      legacy_data_address        <= '0;
    end
    else
    begin
      if (mchk_go)
        mchk_syndrome <= mchk_req.cause
                         | {30'h0, pin_sync};
      else if (hit(ra, icd_pkg::A_MSYND, reg_req.wr))
        mchk_syndrome <= wd;
      if (mchk_go & mchk_req.addr_valid)
        mchk_address <= mchk_req.addr;
      else if (hit(ra, icd_pkg::A_MADDR, reg_req.wr))
        mchk_address <= wd;
      if (dsi_go & ~legacy_mode)
      begin
        exception_syndrome <= dfault.cause;
        data_fault_address <= dfault.ea;
      end
      else
      begin
        if (hit(ra, icd_pkg::A_ESYND, reg_req.wr))
          exception_syndrome <= wd;
        if (hit(ra, icd_pkg::A_DFADDR, reg_req.wr))
          data_fault_address <= wd;
      end
      if (dsi_go & legacy_mode)
      begin
        legacy_data_storage_status <= dfault.cause;
        legacy_data_address        <= (dfault.cause != '0) ? dfault.ea : '0;
      end
      else
      begin
        if (hit(ra, icd_pkg::A_LDSTAT, reg_req.wr))
          legacy_data_storage_status <= wd;
        if (hit(ra, icd_pkg::A_LDADDR, reg_req.wr))
          legacy_data_address <= wd;
      end
    end
  end

  // Offset slots; only low sixteen bits hold offset, aligned to 16 bytes
  genvar gi;
  generate
    for (gi = 0; gi < icd_pkg::NSLOT; gi++)
    begin : g_slot
      always_ff @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
          vector_offset_slot[gi] <= '0;
        else if (w_slot & (ra[3:0] == 4'(gi)))
          vector_offset_slot[gi] <= {16'h0, wd[15:4], 4'h0};
      end
    end
  endgenerate

  // Checkstop is left only by reset; sticky events, set wins over clear
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_state <= icd_pkg::ICD_RUN;
      irq_stat  <= '0;
      irq_mask  <= '0;
    end
    else
    begin
      unique case (run_state)
        icd_pkg::ICD_RUN:  if (stop_go) run_state <= icd_pkg::ICD_STOP;
        icd_pkg::ICD_STOP: run_state <= icd_pkg::ICD_STOP;
        default:           run_state <= icd_pkg::ICD_STOP;
      endcase
      irq_stat <= ev_set | (irq_stat &
                  ~(hit(ra, icd_pkg::A_IRQ_STAT, reg_req.wr) ? wd[icd_pkg::NEV-1:0] : '0));
      if (hit(ra, icd_pkg::A_IRQ_MASK, reg_req.wr))
        irq_mask <= wd[icd_pkg::NEV-1:0];
    end
  end

  assign checkstop = ~running;
  assign irq       = |(irq_stat & irq_mask);

  // Read mux, data in the cycle after the strobe
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    if (ra[5:4] == icd_pkg::A_SLOT_BASE[5:4])
      rd_mux = vector_offset_slot[ra[3:0]];
    else
      unique case (ra)
        icd_pkg::A_PREFIX:   rd_mux = vector_prefix;
        icd_pkg::A_MSTATE:   rd_mux = machine_state;
        icd_pkg::A_SAVE_PC:  rd_mux = save_pc;
        icd_pkg::A_SAVE_ST:  rd_mux = save_state;
        icd_pkg::A_CSAVE_PC: rd_mux = critical_save_pc;
        icd_pkg::A_CSAVE_ST: rd_mux = critical_save_state;
        icd_pkg::A_MSAVE_PC: rd_mux = mchk_save_pc;
        icd_pkg::A_MSAVE_ST: rd_mux = mchk_save_state;
        icd_pkg::A_MSYND:    rd_mux = mchk_syndrome;
        icd_pkg::A_MADDR:    rd_mux = mchk_address;
        icd_pkg::A_ESYND:    rd_mux = exception_syndrome;
        icd_pkg::A_DFADDR:   rd_mux = data_fault_address;
        icd_pkg::A_LDSTAT:   rd_mux = legacy_data_storage_status;
        icd_pkg::A_LDADDR:   rd_mux = legacy_data_address;
        icd_pkg::A_IRQ_STAT: rd_mux = {28'h0, irq_stat};
        icd_pkg::A_IRQ_MASK: rd_mux = {28'h0, irq_mask};
        icd_pkg::A_STATUS:   rd_mux = {29'h0, checkstop, legacy_mode, running};
        default:             rd_mux = '0;
      endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= '0;
    else
      reg_rdata <= reg_req.rd ? rd_mux : '0;
  end
endmodule

//--- tb/icd_dispatch_properties.sv
// Checker: port-level temporal properties of the dispatch unit
`timescale 1ns/1ps
module icd_dispatch_properties (
  input wire logic                ref_clk,
  input wire logic                resetn,
  input wire logic                bus_parity_err,
  input wire icd_pkg::icd_mchk_s  mchk_req,
  input wire logic                ret_noncrit,
  input wire logic                ret_crit,
  input wire logic                ret_mchk,
  input wire icd_pkg::icd_reg_s   reg_req,
  input wire logic [31:0]         reg_rdata,
  input wire logic                take_valid,
  input wire icd_pkg::icd_class_e take_class,
  input wire logic [31:0]         new_pc,
  input wire logic                pc_load,
  input wire logic                checkstop
);
  // One domain, so clock and reset are given once for all
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // Entries and returns both announce a new program counter
  a_take_loads_pc: assert property (take_valid |-> pc_load)
    else $error("take without pc load");
  a_return_loads_pc: assert property (
    (ret_noncrit || ret_crit || ret_mchk) && !checkstop |=> pc_load)
    else $error("return without pc load");
  // Checkstop is final until reset, so nothing may be taken once it shows
  a_stop_sticky: assert property (checkstop |=> checkstop)
    else $error("checkstop dropped");
  a_stop_no_take: assert property ($past(checkstop) |-> !take_valid)
    else $error("interrupt taken in checkstop");
  // Pins pass a synchroniser, so the window is wider than for the same-clock request
  a_pin_mchk_acts: assert property (
    $rose(bus_parity_err) |-> ##[1:6] (checkstop || take_valid && take_class == icd_pkg::ICD_MCHK))
    else $error("parity pin ignored");
  a_req_mchk_acts: assert property (
    mchk_req.valid |-> ##[1:2] (checkstop || take_valid && take_class == icd_pkg::ICD_MCHK))
    else $error("machine check ignored");
  // Read data stand only in the cycle after a read strobe
  a_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  // Handler address and class hold between entries and returns
  a_pc_holds: assert property (!pc_load |-> $stable(new_pc))
    else $error("new pc moved without load");
  a_class_holds: assert property (!pc_load |-> $stable(take_class))
    else $error("class moved without load");
endmodule

bind icd_dispatch icd_dispatch_properties u_props (
  .ref_clk, .resetn, .bus_parity_err, .mchk_req, .ret_noncrit, .ret_crit, .ret_mchk,
  .reg_req, .reg_rdata, .take_valid, .take_class, .new_pc, .pc_load, .checkstop
);

//--- tb/icd_pic_model.sv
// Model of the interrupt controller and the machine-check pin sources
`timescale 1ns/1ps
module icd_pic_model (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       raise_crit,
  input  wire logic       raise_ext,
  input  wire logic       ack,
  input  wire logic [1:0] pin_fault,
  output logic            crit_in,
  output logic            ext_in,
  output logic            bus_parity_err,
  output logic            bad_phys_addr
);
  // Requests stay up until software acknowledges them, as a real controller does
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      crit_in <= 1'b0;
      ext_in  <= 1'b0;
      {bad_phys_addr, bus_parity_err} <= 2'h0;
    end
    else
    begin
      crit_in <= raise_crit | (crit_in & ~ack);
      ext_in  <= raise_ext | (ext_in & ~ack);
      {bad_phys_addr, bus_parity_err} <= pin_fault;
    end
  end
endmodule

//--- tb/tb.sv
// Testbench: scenario tasks around the dispatch unit and its controller model
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] PFX    = 32'h1234_0000;
  localparam logic [31:0] EXT_EN = 32'h1 << icd_pkg::MS_EE;
  localparam logic [31:0] ALL_EN = EXT_EN | (32'h1 << icd_pkg::MS_CE) | (32'h1 << icd_pkg::MS_ME);
  localparam logic [31:0] HIGH_B = 32'h1 << icd_pkg::MS_IP;
  localparam logic [1:0]  NC     = icd_pkg::ICD_NONCRIT;
  localparam logic [1:0]  CR     = icd_pkg::ICD_CRIT;
  localparam logic [1:0]  MC     = icd_pkg::ICD_MCHK;
  logic                 ref_clk, resetn, legacy_mode, sys_reset_req, wdog_req, debug_req;
  logic                 signal_proc_ext_req, perf_mon_req, ret_noncrit, ret_crit, ret_mchk;
  logic                 raise_crit, raise_ext, ack, take_valid, pc_load, checkstop, irq;
  logic                 crit_in, ext_in, bus_parity_err, bad_phys_addr;
  logic [1:0]           pin_fault;
  logic [31:0]          cur_pc, reg_rdata, new_pc;
  icd_pkg::icd_mchk_s   mchk_req;
  icd_pkg::icd_dfault_s dfault;
  icd_pkg::icd_reg_s    reg_req;
  icd_pkg::icd_class_e  take_class;
  int                   fails, checks;

  icd_dispatch uut (.ref_clk, .resetn, .legacy_mode, .sys_reset_req, .crit_in, .wdog_req,
    .debug_req, .ext_in, .signal_proc_ext_req, .perf_mon_req, .bus_parity_err,
    .bad_phys_addr, .mchk_req, .dfault, .cur_pc, .ret_noncrit, .ret_crit, .ret_mchk,
    .reg_req, .reg_rdata, .take_valid, .take_class, .new_pc, .pc_load, .checkstop, .irq);
  icd_pic_model pic (.ref_clk, .resetn, .raise_crit, .raise_ext, .ack, .pin_fault,
    .crit_in, .ext_in, .bus_parity_err, .bad_phys_addr);

  // Free-running core clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Register port: one-cycle strobes, read data in the following cycle only
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk) reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk) reg_req <= '0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    @(posedge ref_clk) reg_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge ref_clk) reg_req <= '0;
    #1 chk(reg_rdata, exp);
  endtask

  // Waits a bounded time for an entry; looks first, since the pulse lasts one cycle
  task automatic take(input logic [1:0] cls, input logic [31:0] vec);
    int n;
    n = 0;
    #1;
    while (take_valid !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(take_valid, 32'h1);
    chk(take_class, cls);
    chk(new_pc, vec);
  endtask

  task automatic quiet(input int n);
    repeat (n) @(posedge ref_clk) #1 chk(take_valid, 32'h0);
  endtask

  task automatic ret(input int k, input logic [31:0] pc);
    @(posedge ref_clk) {ret_mchk, ret_crit, ret_noncrit} <= 3'h1 << k;
    @(posedge ref_clk) {ret_mchk, ret_crit, ret_noncrit} <= 3'h0;
    #1 chk(pc_load, 32'h1);
    chk(new_pc, pc);
  endtask

  task automatic pulse_ack;
    @(posedge ref_clk) ack <= 1'b1;
    @(posedge ref_clk) ack <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic s_init;
    rd(icd_pkg::A_MSTATE, icd_pkg::MSTATE_RST);
    wr(6'h3f, 32'hffff_ffff);
    rd(6'h3f, 32'h0);
    wr(icd_pkg::A_PREFIX, PFX);
    rd(icd_pkg::A_PREFIX, PFX);
    for (int i = 0; i < 6; i++)
      wr(icd_pkg::A_SLOT_BASE + 6'(i), 32'(i + 1) << 8);
  endtask

  task automatic s_crit;
    @(posedge ref_clk) cur_pc <= 32'h0000_4440;
    wr(icd_pkg::A_MSTATE, ALL_EN);
    @(posedge ref_clk) raise_crit <= 1'b1;
    @(posedge ref_clk) raise_crit <= 1'b0;
    take(CR, PFX | 32'h100);
    rd(icd_pkg::A_CSAVE_PC, 32'h0000_4440);
    rd(icd_pkg::A_CSAVE_ST, ALL_EN);
    rd(icd_pkg::A_SAVE_PC, 32'h0);
    pulse_ack;
    ret(1, 32'h0000_4440);
    rd(icd_pkg::A_MSTATE, ALL_EN);
  endtask

  // Gated requests wait; prefix mode has no reset vector at all
  task automatic s_gate;
    wr(icd_pkg::A_MSTATE, 32'h0);
    @(posedge ref_clk) {raise_crit, raise_ext, sys_reset_req} <= 3'h7;
    @(posedge ref_clk) {raise_crit, raise_ext} <= 2'h0;
    quiet(8);
    sys_reset_req <= 1'b0;
    wr(icd_pkg::A_MSTATE, EXT_EN);
    take(NC, PFX | 32'h500);
    pulse_ack;
    for (int k = 0; k < 2; k++)
    begin
      wr(icd_pkg::A_MSTATE, EXT_EN);
      @(posedge ref_clk) {perf_mon_req, signal_proc_ext_req} <= 2'(k + 1);
      take(NC, PFX | 32'h600);
      @(posedge ref_clk) {perf_mon_req, signal_proc_ext_req} <= 2'h0;
    end
  endtask

  task automatic s_irq;
    #1 chk(irq, 32'h0);
    wr(icd_pkg::A_IRQ_MASK, 32'h4);
    #1 chk(irq, 32'h1);
    wr(icd_pkg::A_IRQ_STAT, 32'h4);
    #1 chk(irq, 32'h0);
  endtask

  // Machine check beats a pending watchdog; the watchdog follows the return
  task automatic s_prio;
    @(posedge ref_clk) cur_pc <= 32'h0000_8880;
    wr(icd_pkg::A_MSTATE, ALL_EN);
    @(posedge ref_clk) mchk_req <= '{1'b1, 32'h0000_0010, 1'b1, 32'h00ab_cd00};
    wdog_req <= 1'b1;
    @(posedge ref_clk) mchk_req <= '0;
    take(MC, PFX | 32'h200);
    rd(icd_pkg::A_MSAVE_PC, 32'h0000_8880);
    rd(icd_pkg::A_MSAVE_ST, ALL_EN);
    rd(icd_pkg::A_CSAVE_PC, 32'h0000_4440);
    rd(icd_pkg::A_MSYND, 32'h0000_0010);
    rd(icd_pkg::A_MADDR, 32'h00ab_cd00);
    ret(2, 32'h0000_8880);
    take(CR, PFX | 32'h100);
    @(posedge ref_clk) wdog_req <= 1'b0;
    wr(icd_pkg::A_MSTATE, ALL_EN);
    @(posedge ref_clk) debug_req <= 1'b1;
    take(CR, PFX | 32'h100);
    @(posedge ref_clk) debug_req <= 1'b0;
  endtask

  task automatic s_dfault(input logic [31:0] vec, input logic [5:0] st, input logic [5:0] ad);
    wr(icd_pkg::A_MSTATE, ALL_EN);
    @(posedge ref_clk) dfault <= '{1'b1, 32'h0000_0080, 32'hdead_bee0};
    @(posedge ref_clk) dfault <= '0;
    take(NC, vec);
    rd(st, 32'h0000_0080);
    rd(ad, 32'hdead_bee0);
    ret(0, 32'h0000_8880);
  endtask

  task automatic s_stop;
    wr(icd_pkg::A_MSTATE, 32'h0);
    @(posedge ref_clk) pin_fault <= 2'h1;
    repeat (6) @(posedge ref_clk);
    #1 chk(checkstop, 32'h1);
    wr(icd_pkg::A_MSTATE, ALL_EN);
    @(posedge ref_clk) raise_crit <= 1'b1;
    @(posedge ref_clk) raise_crit <= 1'b0;
    quiet(8);
  endtask

  // Mode changes only under reset; checkstop clears with it
  task automatic s_legacy;
    @(posedge ref_clk) resetn <= 1'b0;
    legacy_mode <= 1'b1;
    pin_fault <= 2'h0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    #1 chk(checkstop, 32'h0);
    wr(icd_pkg::A_MSTATE, ALL_EN);
    @(posedge ref_clk) sys_reset_req <= 1'b1;
    take(NC, 32'h0000_0100);
    sys_reset_req <= 1'b0;
    s_dfault(32'h0000_0300, icd_pkg::A_LDSTAT, icd_pkg::A_LDADDR);
    wr(icd_pkg::A_MSTATE, ALL_EN | HIGH_B);
    @(posedge ref_clk) mchk_req <= '{1'b1, 32'h0000_0004, 1'b0, 32'h0};
    @(posedge ref_clk) mchk_req <= '0;
    take(MC, 32'hfff0_0200);
  endtask

  initial
  begin
    {resetn, legacy_mode, sys_reset_req, wdog_req, debug_req, signal_proc_ext_req} = '0;
    {perf_mon_req, ret_noncrit, ret_crit, ret_mchk, raise_crit, raise_ext, ack} = '0;
    {pin_fault, cur_pc, mchk_req, dfault, reg_req, fails, checks} = '0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    s_init;
    s_crit;
    s_gate;
    s_irq;
    s_prio;
    s_dfault(PFX | 32'h300, icd_pkg::A_ESYND, icd_pkg::A_DFADDR);
    s_stop;
    s_legacy;
    close_out;
  end

  // Watchdog: the scenarios need well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    $display("unexpected at %0t: run hung", $time);
    close_out;
  end
endmodule
